/* File: hw/ssp_defines.vh */
// Register offsets, field positions, reset values and mode codes
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// Register offsets on the plain register port
`define SSP_OFS_GLB_INT 8'h0b
`define SSP_OFS_PER_FLG 8'h0c
`define SSP_OFS_SHBUF 8'h13
`define SSP_OFS_CTRL 8'h14
`define SSP_OFS_PC_DIR 8'h87
`define SSP_OFS_PER_EN 8'h8c
`define SSP_OFS_ADDR 8'h93
`define SSP_OFS_STAT 8'h94

// Control register fields
`define SSP_CTRL_COLL 7
`define SSP_CTRL_OVF 6
`define SSP_CTRL_EN 5
`define SSP_CTRL_REL 4

// Status register fields
`define SSP_STAT_SAMPLE 7
`define SSP_STAT_EDGE 6
`define SSP_STAT_DATA 5
`define SSP_STAT_STOP 4
`define SSP_STAT_START 3
`define SSP_STAT_READ 2
`define SSP_STAT_FULL 0

// Port flag, enable and direction bits
`define SSP_PER_IRQ 3
`define SSP_PC_SCL 3
`define SSP_PC_SDA 4

// Reset values
`define SSP_RST_ZERO 8'h00
`define SSP_RST_PC_DIR 8'hff

// Mode select codes
`define SSP_MODE_S7 4'h6
`define SSP_MODE_S10 4'h7
`define SSP_MODE_MST 4'hb
`define SSP_MODE_S7I 4'he
`define SSP_MODE_S10I 4'hf

// Bit slots in one byte frame
`define SSP_LAST_DATA 4'h8
`define SSP_ACK_SLOT 4'h9

`endif

/* File: hw/ssp_sync.v */
// Two-stage synchroniser for the bus pins
`timescale 1ns/1ps

module ssp_sync
#(
    parameter WIDTH = 2
)
(
    input wire i_clk,
    input wire i_rst_b,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);

reg [WIDTH-1:0] meta_q;

// Idle bus is high, so both stages reset to one
always @(posedge i_clk or negedge i_rst_b)
begin
    if (!i_rst_b)
    begin
        meta_q <= {WIDTH{1'b1}};
        o_sync <= {WIDTH{1'b1}};
    end
    else
    begin
        meta_q <= i_async;
        o_sync <= meta_q;
    end
end

endmodule

/* File: hw/ssp_i2c_slave.v */
// Two-wire serial port: slave transmitter, bus monitor and registers
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ssp_defines.vh"
// ************************************************************
// ************************************************************

module ssp_i2c_slave
(
    input wire I_REF_CLK,
    input wire I_RST_B,
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [7:0] O_RDATA,
    input wire I_SCL,
    output reg O_SCL,
    output reg O_SCL_OE,
    input wire I_SDA,
    output reg O_SDA,
    output reg O_SDA_OE
);

// ************************************************************
// Slave sequencer states
// ************************************************************
localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_RX = 3'd2;
localparam ST_TX = 3'd3;
localparam ST_IGN = 3'd4;

// Modes in which the slave logic takes part
function slave_mode;
    input [3:0] m;
    begin
        slave_mode = (m == `SSP_MODE_S7) || (m == `SSP_MODE_S10) ||
            (m == `SSP_MODE_S7I) || (m == `SSP_MODE_S10I);
    end
endfunction

// Modes with START/STOP interrupts
function cond_irq_mode;
    input [3:0] m;
    begin
        cond_irq_mode = (m == `SSP_MODE_MST) || (m == `SSP_MODE_S7I) ||
            (m == `SSP_MODE_S10I);
    end
endfunction

// ************************************************************
// Registers and their next values
// ************************************************************
reg [7:0] glb_q, glb_d;
reg [7:0] pflg_q, pflg_d;
reg [7:0] pen_q, pen_d;
reg [7:0] pdir_q, pdir_d;
reg [7:0] addr_q, addr_d;
reg [7:0] buf_q, buf_d;
reg [7:0] sr_q, sr_d;
reg [3:0] mode_q, mode_d;
reg coll_q, coll_d;
reg ovf_q, ovf_d;
reg en_q, en_d;
reg rel_q, rel_d;
reg sample_q, sample_d;
reg edge_q, edge_d;
reg data_q, data_d;
reg stop_q, stop_d;
reg start_q, start_d;
reg read_q, read_d;
reg full_q, full_d;
reg [2:0] st_q, st_d;
reg [3:0] bit_q, bit_d;
reg ack_q, ack_d;
reg str_q, str_d;
reg pend_q, pend_d;
reg scl_p_q;
reg sda_p_q;
reg [7:0] rdata_d;
reg scl_oe_d;
reg sda_oe_d;
reg flag_set;
reg active;

wire [1:0] pins_s;
wire scl_s = pins_s[0];
wire sda_s = pins_s[1];
wire rise_ev = scl_s && !scl_p_q;
wire fall_ev = !scl_s && scl_p_q;
wire start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
wire stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
wire wr_buf = I_WR && (I_ADDR == `SSP_OFS_SHBUF);
wire wr_ctrl = I_WR && (I_ADDR == `SSP_OFS_CTRL);
wire wr_stat = I_WR && (I_ADDR == `SSP_OFS_STAT);
wire wr_pflg = I_WR && (I_ADDR == `SSP_OFS_PER_FLG);
wire wr_pen = I_WR && (I_ADDR == `SSP_OFS_PER_EN);
wire [7:0] ctrl_v = {coll_q, ovf_q, en_q, rel_q, mode_q};
wire [7:0] stat_v = {sample_q, edge_q, data_q, stop_q, start_q,
    read_q, 1'b0, full_q};

// ************************************************************
// Pin synchronisers
// ************************************************************
ssp_sync #(
    .WIDTH(2)
) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_async({I_SDA, I_SCL}),
    .o_sync(pins_s)
);

// ************************************************************
// Next-state logic
// ************************************************************
// Software writes first, then bus events; hardware sets win
always @*
begin
    glb_d = glb_q;
    pflg_d = pflg_q;
    pen_d = pen_q;
    pdir_d = pdir_q;
    addr_d = addr_q;
    buf_d = buf_q;
    sr_d = sr_q;
    mode_d = mode_q;
    coll_d = coll_q;
    ovf_d = ovf_q;
    en_d = en_q;
    rel_d = rel_q;
    sample_d = sample_q;
    edge_d = edge_q;
    data_d = data_q;
    stop_d = stop_q;
    start_d = start_q;
    read_d = read_q;
    full_d = full_q;
    st_d = st_q;
    bit_d = bit_q;
    ack_d = ack_q;
    str_d = str_q;
    pend_d = pend_q;
    flag_set = 1'b0;
    active = (st_q == ST_ADDR) || (st_q == ST_RX) || (st_q == ST_TX);

    // Software writes; bits that hardware sets are overridden below
    if (I_WR && (I_ADDR == `SSP_OFS_GLB_INT))
        glb_d = I_WDATA;
    if (wr_pflg)
        pflg_d = I_WDATA;
    if (wr_pen)
    begin
        pen_d = I_WDATA;
        // Enabling while the bus is busy defers to the next STOP
        if (I_WDATA[`SSP_PER_IRQ] && !pen_q[`SSP_PER_IRQ] && start_q)
            pend_d = 1'b1;
    end
    if (I_WR && (I_ADDR == `SSP_OFS_PC_DIR))
        pdir_d = I_WDATA;
    if (I_WR && (I_ADDR == `SSP_OFS_ADDR))
        addr_d = I_WDATA;
    if (wr_ctrl)
    begin
        coll_d = I_WDATA[`SSP_CTRL_COLL];
        ovf_d = I_WDATA[`SSP_CTRL_OVF];
        en_d = I_WDATA[`SSP_CTRL_EN];
        rel_d = I_WDATA[`SSP_CTRL_REL];
        mode_d = I_WDATA[3:0];
    end
    if (wr_stat)
    begin
        // Only the two select bits are writable
        sample_d = I_WDATA[`SSP_STAT_SAMPLE];
        edge_d = I_WDATA[`SSP_STAT_EDGE];
    end
    if (I_RD && (I_ADDR == `SSP_OFS_SHBUF))
        full_d = 1'b0;
    if (wr_buf)
    begin
        // A write while a byte is shifting out is dropped
        if ((st_q == ST_TX) && !str_q && (bit_q < `SSP_LAST_DATA))
            coll_d = 1'b1;
        else
        begin
            buf_d = I_WDATA;
            sr_d = I_WDATA;
        end
    end

    // Bus events; disabling clears START/STOP status in the write's own cycle
    if (!en_d)
    begin
        st_d = ST_IDLE;
        bit_d = 4'h0;
        ack_d = 1'b0;
        str_d = 1'b0;
        start_d = 1'b0;
        stop_d = 1'b0;
    end
    else if (start_ev)
    begin
        start_d = 1'b1;
        stop_d = 1'b0;
        if (cond_irq_mode(mode_q))
            flag_set = 1'b1;
        // Mode 1011 leaves the slave idle
        st_d = slave_mode(mode_q) ? ST_ADDR : ST_IDLE;
        bit_d = 4'h0;
        ack_d = 1'b0;
        str_d = 1'b0;
        data_d = 1'b0;
    end
    else if (stop_ev)
    begin
        stop_d = 1'b1;
        start_d = 1'b0;
        if (cond_irq_mode(mode_q) || pend_q)
            flag_set = 1'b1;
        pend_d = 1'b0;
        st_d = ST_IDLE;
        bit_d = 4'h0;
        ack_d = 1'b0;
        str_d = 1'b0;
    end
    else if (rise_ev && active)
    begin
        if (bit_q < `SSP_LAST_DATA)
        begin
            // Sampling happens only in slave states and is skipped while the slave transmits
            if (st_q != ST_TX)
                sr_d = {sr_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
        end
        else if (bit_q == `SSP_LAST_DATA)
        begin
            bit_d = `SSP_ACK_SLOT;
            // Ninth rising edge: high SDA means no acknowledge
            if ((st_q == ST_TX) && sda_s)
            begin
                st_d = ST_IDLE;
                bit_d = 4'h0;
                read_d = 1'b0;
                data_d = 1'b0;
                full_d = 1'b0;
            end
        end
    end
    else if (fall_ev && active)
    begin
        if ((st_q == ST_TX) && (bit_q != 4'h0) &&
            (bit_q < `SSP_LAST_DATA))
            sr_d = {sr_q[6:0], 1'b0};
        else if ((bit_q == `SSP_LAST_DATA) && (st_q != ST_TX))
        begin
            // Eighth falling edge: byte decision
            if (st_q == ST_ADDR)
            begin
                if (sr_q[7:1] != addr_q[7:1])
                    st_d = ST_IGN;
                else if (!full_q && !ovf_q)
                begin
                    buf_d = sr_q;
                    full_d = 1'b1;
                    read_d = sr_q[0];
                    data_d = 1'b0;
                    ack_d = 1'b1;
                    st_d = sr_q[0] ? ST_TX : ST_RX;
                end
                else
                begin
                    ovf_d = full_q ? 1'b1 : ovf_q;
                    st_d = ST_RX;
                end
            end
            else if (!full_q && !ovf_q)
            begin
                buf_d = sr_q;
                full_d = 1'b1;
                data_d = 1'b1;
                ack_d = 1'b1;
            end
            else if (full_q)
                ovf_d = 1'b1;
        end
        else if (bit_q == `SSP_ACK_SLOT)
        begin
            // Ninth falling edge: byte done
            ack_d = 1'b0;
            flag_set = 1'b1;
            bit_d = 4'h0;
            if (st_q == ST_TX)
            begin
                str_d = 1'b1;
                rel_d = 1'b0;
            end
        end
    end

    // Stretch ends once software sets the release bit
    if (str_q && rel_q)
        str_d = 1'b0;
    if (flag_set)
        pflg_d[`SSP_PER_IRQ] = 1'b1;
end

// ************************************************************
// Read mux and pin drive
// ************************************************************
// Open drain: an enable only ever pulls a line low
always @*
begin
    rdata_d = 8'h00;
    if (!I_RD)
        rdata_d = 8'h00;
    else if (I_ADDR == `SSP_OFS_GLB_INT)
        rdata_d = glb_q;
    else if (I_ADDR == `SSP_OFS_PER_FLG)
        rdata_d = pflg_q;
    else if (I_ADDR == `SSP_OFS_SHBUF)
        rdata_d = buf_q;
    else if (I_ADDR == `SSP_OFS_CTRL)
        rdata_d = ctrl_v;
    else if (I_ADDR == `SSP_OFS_PC_DIR)
        rdata_d = pdir_q;
    else if (I_ADDR == `SSP_OFS_PER_EN)
        rdata_d = pen_q;
    else if (I_ADDR == `SSP_OFS_ADDR)
        rdata_d = addr_q;
    else if (I_ADDR == `SSP_OFS_STAT)
        rdata_d = stat_v;
    scl_oe_d = en_q && (!pdir_q[`SSP_PC_SCL] || str_q);
    sda_oe_d = en_q && (!pdir_q[`SSP_PC_SDA] || ack_q ||
        ((st_q == ST_TX) && (bit_q < `SSP_LAST_DATA) && !sr_q[7]));
end

// ************************************************************
// State registers
// ************************************************************
always @(posedge I_REF_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
    begin
        glb_q <= `SSP_RST_ZERO;
        pflg_q <= `SSP_RST_ZERO;
        pen_q <= `SSP_RST_ZERO;
        pdir_q <= `SSP_RST_PC_DIR;
        addr_q <= `SSP_RST_ZERO;
        buf_q <= `SSP_RST_ZERO;
        sr_q <= `SSP_RST_ZERO;
        mode_q <= 4'h0;
        coll_q <= 1'b0;
        ovf_q <= 1'b0;
        en_q <= 1'b0;
        rel_q <= 1'b0;
        sample_q <= 1'b0;
        edge_q <= 1'b0;
        data_q <= 1'b0;
        stop_q <= 1'b0;
        start_q <= 1'b0;
        read_q <= 1'b0;
        full_q <= 1'b0;
        st_q <= ST_IDLE;
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        str_q <= 1'b0;
        pend_q <= 1'b0;
        scl_p_q <= 1'b1;
        sda_p_q <= 1'b1;
        O_RDATA <= 8'h00;
        O_SCL <= 1'b0;
        O_SCL_OE <= 1'b0;
        O_SDA <= 1'b0;
        O_SDA_OE <= 1'b0;
    end
    else
    begin
        glb_q <= glb_d;
        pflg_q <= pflg_d;
        pen_q <= pen_d;
        pdir_q <= pdir_d;
        addr_q <= addr_d;
        buf_q <= buf_d;
        sr_q <= sr_d;
        mode_q <= mode_d;
        coll_q <= coll_d;
        ovf_q <= ovf_d;
        en_q <= en_d;
        rel_q <= rel_d;
        sample_q <= sample_d;
        edge_q <= edge_d;
        data_q <= data_d;
        stop_q <= stop_d;
        start_q <= start_d;
        read_q <= read_d;
        full_q <= full_d;
        st_q <= st_d;
        bit_q <= bit_d;
        ack_q <= ack_d;
        str_q <= str_d;
        pend_q <= pend_d;
        scl_p_q <= scl_s;
        sda_p_q <= sda_s;
        O_RDATA <= rdata_d;
        O_SCL <= 1'b0; // Driven level is always low
        O_SCL_OE <= scl_oe_d;
        O_SDA <= 1'b0;
        O_SDA_OE <= sda_oe_d;
    end
end

endmodule

/* File: tb/ssp_i2c_chk.sv */
// Checker for the pins and register port of the serial port
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_i2c_chk
(
    input wire I_REF_CLK,
    input wire I_RST_B,
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire [7:0] O_RDATA,
    input wire I_SCL,
    input wire O_SCL,
    input wire O_SCL_OE,
    input wire I_SDA,
    input wire O_SDA,
    input wire O_SDA_OE
);
    // ****************
    // Pin and register properties
    // ****************
    reg [1:0] dir_q;
    reg [4:0] ctl_q;
    // Shadow of pin directions, enable and mode; hardware never moves them
    always @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            dir_q <= 2'b11;
            ctl_q <= 5'h00;
        end
        else if (I_WR && I_ADDR == `SSP_OFS_PC_DIR)
            dir_q <= I_WDATA[4:3];
        else if (I_WR && I_ADDR == `SSP_OFS_CTRL)
            ctl_q <= {I_WDATA[5], I_WDATA[3:0]};
    end
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_B);
    sequence s_rel_wr;
        dir_q[0] && I_WR && I_ADDR == `SSP_OFS_CTRL && I_WDATA[4];
    endsequence
    // Reads while the slave stretches; firmware SCL drive excluded
    sequence s_held_rd(a);
        dir_q[0] && O_SCL_OE && I_RD && I_ADDR == a;
    endsequence
    property p_pin_low;
        O_SCL == 1'b0 && O_SDA == 1'b0;
    endproperty
    property p_pin_drv;
        I_WR && I_ADDR == `SSP_OFS_PC_DIR && !I_WDATA[4] && ctl_q[4]
            |-> ##[1:3] O_SDA_OE;
    endproperty
    // Three cycles of settling after a direction change are excused
    property p_sda_edge;
        dir_q[1] && $past(dir_q[1], 3) && $changed(O_SDA_OE) |-> !I_SCL;
    endproperty
    property p_stretch;
        dir_q[0] && $rose(O_SCL_OE) |-> !I_SCL;
    endproperty
    property p_release;
        s_rel_wr |-> ##[1:3] !O_SCL_OE;
    endproperty
    property p_rel_clr;
        s_held_rd(`SSP_OFS_CTRL) |=> !O_RDATA[4];
    endproperty
    property p_flag_held;
        s_held_rd(`SSP_OFS_PER_FLG) |=> O_RDATA[3];
    endproperty
    property p_dis_clr;
        I_RD && I_ADDR == `SSP_OFS_STAT && !ctl_q[4]
            |=> O_RDATA[4:3] == 2'b00;
    endproperty
    property p_mst_idle;
        ctl_q == 5'h1b && dir_q == 2'b11 && $past(dir_q, 3) == 2'b11
            |-> !O_SDA_OE && !O_SCL_OE;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("pin output level not low");
    a_pin_drv: assert property (p_pin_drv)
        else $error("SDA not driven after direction set to output");
    a_sda_edge: assert property (p_sda_edge)
        else $error("SDA drive changed while SCL high");
    a_stretch: assert property (p_stretch)
        else $error("stretch started while SCL high");
    a_release: assert property (p_release)
        else $error("SCL not released after release bit write");
    a_rel_clr: assert property (p_rel_clr)
        else $error("release bit set while stretching");
    a_flag_held: assert property (p_flag_held)
        else $error("irq flag clear while stretching");
    a_dis_clr: assert property (p_dis_clr)
        else $error("start or stop status set while disabled");
    a_mst_idle: assert property (p_mst_idle)
        else $error("slave drove the bus in master support mode");
endmodule

/* File: tb/ssp_mst_model.sv */
// Behavioural two-wire bus master on the far side of the port
`timescale 1ns/1ps
module ssp_mst_model
(
    input wire i_scl,
    input wire i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    // ****************
    // Bus master tasks, 800 ns bit period
    // ****************
    // Both lines released at start; pull-ups make them high
    initial
    begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end
    // Let SCL go and wait, bounded, while the slave stretches it
    task automatic scl_up;
        o_scl_oe = 1'b0;
        for (int i = 0; i < 5000 && i_scl !== 1'b1; i++)
            #50;
    endtask
    // Odd offset keeps the link out of phase with the system clock
    task automatic start;
        #30 o_sda_oe = 1'b1;
        #300 o_scl_oe = 1'b1;
        #100;
    endtask
    task automatic stop;
        o_sda_oe = 1'b1;
        #450 scl_up;
        #250 o_sda_oe = 1'b0;
        #500;
    endtask
    // Nine slots MSB first; a 1 in tx leaves SDA to the slave
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            o_sda_oe = ~tx[i];
            #450 scl_up;
            #150 rx[i] = i_sda;
            #100 o_scl_oe = 1'b1;
            #100;
        end
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the two-wire serial port block
`timescale 1ns/1ps
`include "ssp_defines.vh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
    // ****************
    // Bench
    // ****************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic scl_oe, sda_oe, m_scl, m_sda;
    logic [7:0] d;
    logic [8:0] rx;
    int bad_count = 0;
    int n_tests = 0;
    // Open-drain wires with pull-ups
    wire scl = !(scl_oe || m_scl);
    wire sda = !(sda_oe || m_sda);
    ssp_i2c_slave u_ssp_i2c_slave (.I_REF_CLK(clk), .I_RST_B(rst_b),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_SCL(scl), .O_SCL(), .O_SCL_OE(scl_oe),
        .I_SDA(sda), .O_SDA(), .O_SDA_OE(sda_oe));
    ssp_mst_model u_ssp_mst_model (.i_scl(scl), .i_sda(sda),
        .o_scl_oe(m_scl), .o_sda_oe(m_sda));
    always #50 clk = ~clk;
    task automatic finish_test;
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Register port: one-cycle strobes, read data only in the next cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e,
        input string n);
        logic [7:0] v;
        rd_reg(a, v);
        `CHK(n, e, v)
    endtask
    // Poll the flag with a bounded count
    task automatic wait_flag;
        logic [7:0] v = 8'h00;
        for (int i = 0; i < 300 && v[3] !== 1'b1; i++)
            rd_reg(`SSP_OFS_PER_FLG, v);
        `CHK("flag", 1'b1, v[3])
    endtask
    task automatic t_reset;
        chk_reg(`SSP_OFS_CTRL, `SSP_RST_ZERO, "ctrl");
        chk_reg(`SSP_OFS_PC_DIR, `SSP_RST_PC_DIR, "dir");
        chk_reg(`SSP_OFS_STAT, `SSP_RST_ZERO, "stat");
        chk_reg(`SSP_OFS_PER_FLG, `SSP_RST_ZERO, "flags");
        chk_reg(`SSP_OFS_ADDR, `SSP_RST_ZERO, "addr");
        wr_reg(`SSP_OFS_STAT, 8'h00);
        wr_reg(8'h01, 8'h5a);
        chk_reg(8'h01, 8'h00, "unmapped");
        wr_reg(`SSP_OFS_ADDR, 8'ha4);
        chk_reg(`SSP_OFS_ADDR, 8'ha4, "addr");
    endtask
    // Software loads the byte, then releases SCL, then clears the flag
    task automatic t_byte(input logic [7:0] v, input logic ack);
        wr_reg(`SSP_OFS_SHBUF, v);
        wr_reg(`SSP_OFS_CTRL, 8'h36);
        wr_reg(`SSP_OFS_PER_FLG, 8'h00);
        u_ssp_mst_model.xfer({8'hff, ack}, rx);
        `CHK("tx byte", v, rx[8:1])
    endtask
    task automatic t_read;
        wr_reg(`SSP_OFS_CTRL, 8'h36);
        u_ssp_mst_model.start();
        u_ssp_mst_model.xfer({8'h11, 1'b1}, rx);
        `CHK("miss ack", 1'b1, rx[0])
        u_ssp_mst_model.stop();
        u_ssp_mst_model.start();
        u_ssp_mst_model.xfer({8'ha5, 1'b1}, rx);
        `CHK("addr ack", 1'b0, rx[0])
        wait_flag;
        `CHK("stretch", 1'b1, scl_oe)
        chk_reg(`SSP_OFS_STAT, 8'h0d, "stat");
        chk_reg(`SSP_OFS_CTRL, 8'h26, "release");
        chk_reg(`SSP_OFS_SHBUF, 8'ha5, "buf");
        t_byte(8'h5a, 1'b0);
        wait_flag;
        `CHK("stretch", 1'b1, scl_oe)
        t_byte(8'hc3, 1'b1);
        repeat (10) @(posedge clk);
        rd_reg(`SSP_OFS_STAT, d);
        `CHK("stat", 3'b000, {d[5], d[2], d[0]})
        `CHK("stretch", 1'b0, scl_oe)
        // Enabling the irq while the bus is busy defers it to the STOP
        wr_reg(`SSP_OFS_PER_FLG, 8'h00);
        wr_reg(`SSP_OFS_PER_EN, 8'h08);
        chk_reg(`SSP_OFS_PER_FLG, 8'h00, "no flag yet");
        u_ssp_mst_model.stop();
        wait_flag;
    endtask
    // Firmware master support with the slave idle
    task automatic t_master;
        wr_reg(`SSP_OFS_PER_FLG, 8'h00);
        wr_reg(`SSP_OFS_CTRL, {4'h2, `SSP_MODE_MST});
        u_ssp_mst_model.start();
        chk_reg(`SSP_OFS_STAT, 8'h08, "start");
        wait_flag;
        u_ssp_mst_model.xfer({8'ha5, 1'b1}, rx);
        `CHK("idle ack", 1'b1, rx[0])
        wr_reg(`SSP_OFS_PER_FLG, 8'h00);
        u_ssp_mst_model.stop();
        chk_reg(`SSP_OFS_STAT, 8'h10, "stop");
        wait_flag;
        wr_reg(`SSP_OFS_PC_DIR, 8'hef);
        repeat (3) @(posedge clk);
        `CHK("sda drive", 1'b0, sda)
        wr_reg(`SSP_OFS_PC_DIR, 8'hff);
        repeat (3) @(posedge clk);
        `CHK("sda free", 1'b1, sda)
        wr_reg(`SSP_OFS_CTRL, {4'h0, `SSP_MODE_MST});
        chk_reg(`SSP_OFS_STAT, 8'h00, "disabled");
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_read;
        t_master;
        finish_test;
    end
    // Watchdog well past the expected run of some 50 us
    initial
    begin
        #2000000;
        bad_count++;
        finish_test;
    end
endmodule
bind ssp_i2c_slave ssp_i2c_chk u_ssp_i2c_chk (.I_REF_CLK(I_REF_CLK),
    .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SCL(I_SCL), .O_SCL(O_SCL),
    .O_SCL_OE(O_SCL_OE), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE));
